// [logic/readout_control.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - data port write pushes word, 512 deep
// - length write flags pending async event
// - data status bit 31 shows full
// - length status bit 31 shows full
// - status low field shows word count
// - last trigger number, cleared by reset
// - acknowledge counter, cleared by reset
// - 64-bit byte counter, cleared by reset
// - low read latches upper half
// - size limit bounds memory and wrap
// - size limit forces block send
// - block count limit forces send
// - idle timeout in 12.8ns forces send
// - pending async sent at block boundary
// - dma reset control active low
module readout_control
   import readout_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event builder side
   input wire logic trigger_valid,
   input wire logic [31:0] trigger_number,
   input wire logic ack_sent,
   input wire logic bytes_valid,
   input wire logic [15:0] bytes_count,
   input wire logic event_block_added,
   input wire logic block_boundary,
   input wire logic [31:0] block_words,
   input wire logic async_pop,
   input wire logic async_len_pop,
   output readout_pkg::stream_word_t async_word,
   output readout_pkg::stream_word_t async_length,
   output logic async_pending,
   output logic async_emit,
   output logic send_block,
   output logic memory_full,
   output logic memory_wrap,
   input wire logic [31:0] memory_pointer,
   output logic block_reset,
   output logic dma_reset_n
);
   import readout_pkg::*;

   // depth must be a power of two that the ten-bit count field can hold
   if (DEPTH < 2 || DEPTH > FIFO_DEPTH || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
      $error("fifo depth must be a power of two from 2 to 512");
   end

   // fifo address width and idle unit in whole cycles
   localparam int AW = $clog2(DEPTH);
   localparam logic [31:0] IDLE_CYCLES = 32'((IDLE_UNIT_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic known;
   logic rd_setup;
   // single-cycle access, never stretched
   assign pready = 1'b1;
   // read data is fetched in the setup cycle
   assign rd_setup = psel & ~penable & ~pwrite;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;

   function automatic logic is_mapped(input logic [11:0] a);
      case (a)
         OFS_CONTROL, OFS_ASYNC_DATA_PORT, OFS_ASYNC_DATA_STATUS, OFS_ASYNC_LENGTH_PORT,
         OFS_ASYNC_LENGTH_STATUS, OFS_LAST_TRIGGER, OFS_BYTES_LOW, OFS_BYTES_HIGH,
         OFS_REPLY_TALLY, OFS_BLOCK_SIZE, OFS_BLOCK_COUNT, OFS_BLOCK_IDLE: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction
   assign known = is_mapped(paddr);
   assign pslverr = psel & penable & ~known;

   // status word: full flag on top, word count in the low field
   function automatic logic [31:0] status_word(input logic full, input logic [AW:0] cnt);
      status_word = {full, 21'h00_0000, COUNT_WIDTH'(cnt)};
   endfunction

   // ----------------------------------------------------------------
   // control and limit registers
   // ----------------------------------------------------------------
   logic [31:0] control_q;
   logic [31:0] block_size_limit_q;
   logic [31:0] block_count_limit_q;
   logic [31:0] block_idle_limit_q;
   logic blk_rst;
   assign blk_rst = control_q[CTL_BLOCK_RESET];
   assign block_reset = blk_rst;
   assign dma_reset_n = control_q[CTL_DMA_RUN_N];

   // software writable settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_q <= RESET_WORD;
         block_size_limit_q <= RESET_WORD;
         block_count_limit_q <= RESET_WORD;
         block_idle_limit_q <= RESET_WORD;
      end else if (wr_en) begin
         case (paddr)
            OFS_CONTROL: control_q <= pwdata & 32'h0000_070f;
            OFS_BLOCK_SIZE: block_size_limit_q <= pwdata;
            OFS_BLOCK_COUNT: block_count_limit_q <= {20'h0_0000, pwdata[11:0]};
            OFS_BLOCK_IDLE: block_idle_limit_q <= pwdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // async fifos
   // ----------------------------------------------------------------
   logic [31:0] data_mem [DEPTH];
   logic [31:0] len_mem [DEPTH];
   logic [AW-1:0] d_wp_q, d_rp_q, l_wp_q, l_rp_q;
   logic [AW:0] d_cnt_q, l_cnt_q;
   logic d_full, l_full, d_push, l_push, d_pop, l_pop;
   assign d_full = (d_cnt_q == (AW+1)'(DEPTH));
   assign l_full = (l_cnt_q == (AW+1)'(DEPTH));
   assign d_push = wr_en && paddr == OFS_ASYNC_DATA_PORT && !d_full;
   assign l_push = wr_en && paddr == OFS_ASYNC_LENGTH_PORT && !l_full;
   assign d_pop = async_pop && d_cnt_q != '0;
   assign l_pop = async_len_pop && l_cnt_q != '0;

   // storage arrays, no reset
   // stale words are masked by the counts and valid flags
   always_ff @(posedge pclk) begin
      if (d_push) data_mem[d_wp_q] <= pwdata;
      if (l_push) len_mem[l_wp_q] <= pwdata;
   end

   // pointers and counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d_wp_q <= '0;
         d_rp_q <= '0;
         d_cnt_q <= '0;
         l_wp_q <= '0;
         l_rp_q <= '0;
         l_cnt_q <= '0;
      end else if (blk_rst) begin
         d_wp_q <= '0;
         d_rp_q <= '0;
         d_cnt_q <= '0;
         l_wp_q <= '0;
         l_rp_q <= '0;
         l_cnt_q <= '0;
      end else begin
         if (d_push) d_wp_q <= d_wp_q + 1'b1;
         if (d_pop) d_rp_q <= d_rp_q + 1'b1;
         if (d_push && !d_pop) d_cnt_q <= d_cnt_q + 1'b1;
         else if (d_pop && !d_push) d_cnt_q <= d_cnt_q - 1'b1;
         if (l_push) l_wp_q <= l_wp_q + 1'b1;
         if (l_pop) l_rp_q <= l_rp_q + 1'b1;
         if (l_push && !l_pop) l_cnt_q <= l_cnt_q + 1'b1;
         else if (l_pop && !l_push) l_cnt_q <= l_cnt_q - 1'b1;
      end
   end

   // head words toward the builder
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         async_word <= '0;
         async_length <= '0;
      end else begin
         async_word.valid <= (d_cnt_q != '0) && !blk_rst;
         async_word.data <= data_mem[d_rp_q];
         async_length.valid <= (l_cnt_q != '0) && !blk_rst;
         async_length.data <= len_mem[l_rp_q];
      end
   end

   // pending event and boundary emission
   // an event is pending while any length word waits
   assign async_pending = (l_cnt_q != '0);
   assign async_emit = async_pending && block_boundary && control_q[CTL_ASYNC_ENABLE];

   // ----------------------------------------------------------------
   // trigger, acknowledge and byte counters
   // ----------------------------------------------------------------
   logic [31:0] last_trigger_q;
   logic [31:0] reply_tally_q;
   logic [63:0] bytes_q;
   logic [31:0] bytes_high_q;

   // counters cleared under block reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_trigger_q <= RESET_WORD;
         reply_tally_q <= RESET_WORD;
         bytes_q <= '0;
      end else if (blk_rst) begin
         last_trigger_q <= RESET_WORD;
         reply_tally_q <= RESET_WORD;
         bytes_q <= '0;
      end else begin
         if (trigger_valid) last_trigger_q <= trigger_number;
         if (ack_sent) reply_tally_q <= reply_tally_q + 32'h0000_0001;
         if (bytes_valid) bytes_q <= bytes_q + {48'h0000_0000_0000, bytes_count};
      end
   end

   // upper half snapshot on low read
   // taken on the edge that loads the low word, so a carry cannot split them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bytes_high_q <= RESET_WORD;
      else if (blk_rst) bytes_high_q <= RESET_WORD;
      else if (rd_setup && paddr == OFS_BYTES_LOW) bytes_high_q <= bytes_q[63:32];
   end

   // ----------------------------------------------------------------
   // network block send decisions
   // ----------------------------------------------------------------
   logic [31:0] blocks_q;
   logic [31:0] idle_cyc_q;
   logic [31:0] idle_units_q;
   logic active_q;
   logic size_hit, count_hit, idle_hit;
   assign size_hit = active_q && block_size_limit_q != '0 && block_words >= block_size_limit_q;
   assign count_hit = active_q && block_count_limit_q != '0 && blocks_q >= block_count_limit_q;
   assign idle_hit = active_q && block_idle_limit_q != '0 && idle_units_q >= block_idle_limit_q;
   assign send_block = size_hit | count_hit | idle_hit;
   assign memory_full = block_size_limit_q != '0 && memory_pointer >= block_size_limit_q;
   assign memory_wrap = block_size_limit_q != '0 && memory_pointer == block_size_limit_q - 32'h0000_0001;

   // block fill and idle timers
   // a send restarts everything, so an add in the same cycle is not counted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blocks_q <= RESET_WORD;
         idle_cyc_q <= RESET_WORD;
         idle_units_q <= RESET_WORD;
         active_q <= 1'b0;
      end else if (blk_rst || send_block) begin
         blocks_q <= RESET_WORD;
         idle_cyc_q <= RESET_WORD;
         idle_units_q <= RESET_WORD;
         active_q <= 1'b0;
      end else if (event_block_added) begin
         blocks_q <= blocks_q + 32'h0000_0001;
         idle_cyc_q <= RESET_WORD;
         idle_units_q <= RESET_WORD;
         active_q <= 1'b1;
      end else if (active_q) begin
         // units of 12.8 ns, rounded up to whole cycles
         if (idle_cyc_q >= IDLE_CYCLES - 32'h0000_0001) begin
            idle_cyc_q <= RESET_WORD;
            idle_units_q <= idle_units_q + 32'h0000_0001;
         end else begin
            idle_cyc_q <= idle_cyc_q + 32'h0000_0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   // read data loaded in the setup cycle, held until the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= RESET_WORD;
      else if (rd_setup) begin
         case (paddr)
            OFS_CONTROL: prdata <= control_q;
            OFS_ASYNC_DATA_STATUS: prdata <= status_word(d_full, d_cnt_q);
            OFS_ASYNC_LENGTH_STATUS: prdata <= status_word(l_full, l_cnt_q);
            OFS_LAST_TRIGGER: prdata <= last_trigger_q;
            OFS_BYTES_LOW: prdata <= bytes_q[31:0];
            OFS_BYTES_HIGH: prdata <= bytes_high_q;
            OFS_REPLY_TALLY: prdata <= reply_tally_q;
            OFS_BLOCK_SIZE: prdata <= block_size_limit_q;
            OFS_BLOCK_COUNT: prdata <= block_count_limit_q;
            OFS_BLOCK_IDLE: prdata <= block_idle_limit_q;
            default: prdata <= RESET_WORD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // bus steps that the checks below start from
   sequence data_write_s;
      wr_en && paddr == OFS_ASYNC_DATA_PORT;
   endsequence

   sequence len_write_s;
      wr_en && paddr == OFS_ASYNC_LENGTH_PORT;
   endsequence

   sequence status_read_s(logic [11:0] a);
      rd_setup && paddr == a;
   endsequence

   // fifo pushes and drops
   data_push_a: assert property (@(posedge pclk) disable iff (!presetn)
      data_write_s and !d_full && !blk_rst && !d_pop |=> d_cnt_q == $past(d_cnt_q) + 1'b1)
      else $error("data write did not push");
   full_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      data_write_s and d_full && !d_pop && !blk_rst |=> d_cnt_q == $past(d_cnt_q))
      else $error("write into full fifo changed count");
   len_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      len_write_s and l_full && !l_pop && !blk_rst |=> l_cnt_q == $past(l_cnt_q))
      else $error("write into full length fifo changed count");
   len_pending_a: assert property (@(posedge pclk) disable iff (!presetn)
      l_push && !blk_rst |=> async_pending)
      else $error("length write left no pending event");

   // status words, loaded in the setup cycle
   data_full_a: assert property (@(posedge pclk) disable iff (!presetn)
      status_read_s(OFS_ASYNC_DATA_STATUS) |=> prdata[STATUS_FULL_BIT] == $past(d_full))
      else $error("data full bit wrong");
   len_full_a: assert property (@(posedge pclk) disable iff (!presetn)
      status_read_s(OFS_ASYNC_LENGTH_STATUS) |=> prdata[STATUS_FULL_BIT] == $past(l_full))
      else $error("length full bit wrong");
   count_field_a: assert property (@(posedge pclk) disable iff (!presetn)
      status_read_s(OFS_ASYNC_LENGTH_STATUS) |=> prdata[AW:0] == $past(l_cnt_q))
      else $error("length word count field wrong");

   // counters under block reset and the coherent byte read
   trigger_take_a: assert property (@(posedge pclk) disable iff (!presetn)
      trigger_valid && !blk_rst |=> last_trigger_q == $past(trigger_number))
      else $error("trigger number not captured");
   tally_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      blk_rst |=> reply_tally_q == '0 && last_trigger_q == '0)
      else $error("counters not cleared by block reset");
   bytes_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      blk_rst |=> bytes_q == '0 && bytes_high_q == '0)
      else $error("byte counter not cleared by block reset");
   bytes_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      status_read_s(OFS_BYTES_LOW) and !blk_rst |=> bytes_high_q == $past(bytes_q[63:32]))
      else $error("upper byte half not latched");

   // block sends, memory limits and control outputs
   count_send_a: assert property (@(posedge pclk) disable iff (!presetn)
      event_block_added && !send_block && !blk_rst && block_count_limit_q != '0
      && blocks_q + 32'h0000_0001 == block_count_limit_q |=> send_block)
      else $error("block count limit did not send");
   send_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      send_block && !blk_rst |=> !active_q && blocks_q == '0 && idle_units_q == '0)
      else $error("send did not restart the block");
   wrap_point_a: assert property (@(posedge pclk) disable iff (!presetn)
      block_size_limit_q != '0 && memory_pointer + 32'h0000_0001 == block_size_limit_q |-> memory_wrap)
      else $error("wrap point missed");
   dma_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == OFS_CONTROL |=> dma_reset_n == $past(pwdata[CTL_DMA_RUN_N]))
      else $error("dma reset control not taken");
   async_emit_a: assert property (@(posedge pclk) disable iff (!presetn)
      async_emit |-> control_q[CTL_ASYNC_ENABLE] && l_cnt_q != '0)
      else $error("async emitted while disabled or empty");
endmodule // readout_control
`default_nettype wire

// [logic/readout_pkg.sv]
`default_nettype none
package readout_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_CONTROL = 12'h000;
   localparam logic [11:0] OFS_ASYNC_DATA_PORT = 12'h020;
   localparam logic [11:0] OFS_ASYNC_DATA_STATUS = 12'h024;
   localparam logic [11:0] OFS_ASYNC_LENGTH_PORT = 12'h028;
   localparam logic [11:0] OFS_ASYNC_LENGTH_STATUS = 12'h02c;
   localparam logic [11:0] OFS_LAST_TRIGGER = 12'h040;
   localparam logic [11:0] OFS_BYTES_LOW = 12'h044;
   localparam logic [11:0] OFS_BYTES_HIGH = 12'h048;
   localparam logic [11:0] OFS_REPLY_TALLY = 12'h04c;
   localparam logic [11:0] OFS_BLOCK_SIZE = 12'h070;
   localparam logic [11:0] OFS_BLOCK_COUNT = 12'h074;
   localparam logic [11:0] OFS_BLOCK_IDLE = 12'h078;
   // control register fields
   localparam int CTL_BLOCK_RESET = 0;
   localparam int CTL_DMA_RUN_N = 3;
   localparam int CTL_ASYNC_ENABLE = 10;
   localparam int STATUS_FULL_BIT = 31;
   localparam int COUNT_WIDTH = 10;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam int FIFO_DEPTH = 512;
   // idle unit of 12.8 ns at 4 ns clock: counted in picoseconds
   localparam int IDLE_UNIT_PS = 12800;
   localparam int CLOCK_PERIOD_PS = 4000;
   // bytes per 32-bit word
   localparam logic [63:0] WORD_BYTES = 64'h0000_0000_0000_0004;

   // one word handed to the event builder
   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } stream_word_t;
endpackage
`default_nettype wire

// [sim/event_builder_model.sv]
`timescale 1ns/1ps
`default_nettype none
module event_builder_model (
   // clock
   input wire logic pclk,
   // strobes toward the register block
   output logic trigger_valid,
   output logic [31:0] trigger_number,
   output logic ack_sent,
   output logic bytes_valid,
   output logic [15:0] bytes_count,
   output logic event_block_added,
   output logic async_pop,
   output logic async_len_pop
);
   // all strobes idle at time zero
   initial begin
      {trigger_valid, ack_sent, bytes_valid, event_block_added, async_pop, async_len_pop} = 6'b00_0000;
      trigger_number = 32'h0000_0000;
      bytes_count = 16'h0000;
   end
   // one-cycle strobe; the qualifier is scrambled once the strobe drops
   task automatic strobe(input int kind, input logic [31:0] val);
      @(posedge pclk);
      case (kind)
         0: begin trigger_valid <= 1'b1; trigger_number <= val; end
         1: ack_sent <= 1'b1;
         2: begin bytes_valid <= 1'b1; bytes_count <= val[15:0]; end
         3: event_block_added <= 1'b1;
         4: async_pop <= 1'b1;
         default: async_len_pop <= 1'b1;
      endcase
      @(posedge pclk);
      {trigger_valid, ack_sent, bytes_valid, event_block_added, async_pop, async_len_pop} <= 6'b00_0000;
      trigger_number <= ~val;
      bytes_count <= ~val[15:0];
   endtask
endmodule // event_builder_model
`default_nettype wire

// [sim/readout_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module readout_control_tb;
   import readout_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, block_words = 32'h0000_0000, memory_pointer = 32'h0000_0000;
   logic pready, pslverr, err, block_boundary = 1'b0, async_pending, async_emit, send_block;
   logic memory_full, memory_wrap, block_reset, dma_reset_n;
   logic trigger_valid, ack_sent, bytes_valid, event_block_added, async_pop, async_len_pop;
   logic [31:0] trigger_number;
   logic [15:0] bytes_count;
   stream_word_t async_word, async_length;
   int n_errors = 0, check_count = 0, sends = 0;
   // ----------------------------------------
   // clock, partner, design
   // ----------------------------------------
   always #2 pclk = ~pclk;
   always @(posedge pclk) if (send_block === 1'b1) sends++;
   event_builder_model eb (.pclk(pclk), .trigger_valid(trigger_valid), .trigger_number(trigger_number),
      .ack_sent(ack_sent), .bytes_valid(bytes_valid), .bytes_count(bytes_count),
      .event_block_added(event_block_added), .async_pop(async_pop), .async_len_pop(async_len_pop));
   readout_control #(.DEPTH(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigger_valid(trigger_valid), .trigger_number(trigger_number), .ack_sent(ack_sent),
      .bytes_valid(bytes_valid), .bytes_count(bytes_count), .event_block_added(event_block_added),
      .block_boundary(block_boundary), .block_words(block_words), .async_pop(async_pop),
      .async_len_pop(async_len_pop), .async_word(async_word), .async_length(async_length),
      .async_pending(async_pending), .async_emit(async_emit), .send_block(send_block),
      .memory_full(memory_full), .memory_wrap(memory_wrap), .memory_pointer(memory_pointer),
      .block_reset(block_reset), .dma_reset_n(dma_reset_n));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, e)
   endtask
   task automatic pulses(input int kind, input int n, input logic [31:0] v);
      repeat (n) eb.strobe(kind, v);
      repeat (2) @(posedge pclk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic reset_values();
      logic [11:0] ofs [9] = '{12'h024, 12'h02c, 12'h040, 12'h044, 12'h048, 12'h04c, 12'h070, 12'h074, 12'h078};
      foreach (ofs[i]) rchk(ofs[i], 32'h0000_0000);
      apb(1'b1, 12'h070, 32'h0000_0010);
      rchk(12'h070, 32'h0000_0010);
      apb(1'b1, 12'h040, 32'h0000_1234);
      rchk(12'h040, 32'h0000_0000);
      rchk(12'h300, 32'h0000_0000);
      `CHK(err, 1'b1)
      `CHK(pready, 1'b1)
   endtask
   task automatic data_fifo();
      for (int i = 0; i < 9; i++) apb(1'b1, OFS_ASYNC_DATA_PORT, 32'hC0DE_0000 + i);
      apb(1'b1, OFS_ASYNC_LENGTH_PORT, 32'h0000_0008);
      rchk(OFS_ASYNC_DATA_STATUS, 32'h8000_0008);
      `CHK(async_pending, 1'b1)
      `CHK(async_length.data, 32'h0000_0008)
      for (int i = 0; i < 8; i++) begin
         `CHK(async_word.valid, 1'b1)
         `CHK(async_word.data, 32'hC0DE_0000 + i)
         pulses(4, 1, 32'h0000_0000);
         if (i == 0) rchk(OFS_ASYNC_DATA_STATUS, 32'h0000_0007);
      end
      rchk(OFS_ASYNC_DATA_STATUS, 32'h0000_0000);
      `CHK(async_word.valid, 1'b0)
      pulses(5, 1, 32'h0000_0000);
      `CHK(async_pending, 1'b0)
   endtask
   task automatic length_fifo();
      `CHK(async_pending, 1'b0)
      for (int i = 1; i < 10; i++) apb(1'b1, OFS_ASYNC_LENGTH_PORT, i);
      rchk(OFS_ASYNC_LENGTH_STATUS, 32'h8000_0008);
      `CHK(async_pending, 1'b1)
      block_boundary <= 1'b1;
      @(posedge pclk);
      `CHK(async_emit, 1'b0)
      apb(1'b1, OFS_CONTROL, 32'h0000_0408);
      @(posedge pclk);
      `CHK(async_emit, 1'b1)
      `CHK(dma_reset_n, 1'b1)
      block_boundary <= 1'b0;
      for (int i = 1; i < 9; i++) begin
         `CHK(async_length.data, i)
         pulses(5, 1, 32'h0000_0000);
      end
      `CHK(async_pending, 1'b0)
   endtask
   task automatic counters();
      pulses(0, 1, 32'hA5A5_0001);
      pulses(1, 3, 32'h0000_0000);
      pulses(2, 2, 32'h0000_1234);
      rchk(OFS_LAST_TRIGGER, 32'hA5A5_0001);
      rchk(OFS_REPLY_TALLY, 32'h0000_0003);
      rchk(OFS_BYTES_LOW, 32'h0000_2468);
      rchk(OFS_BYTES_HIGH, 32'h0000_0000);
      apb(1'b1, OFS_CONTROL, 32'h0000_0001);
      @(posedge pclk);
      `CHK(block_reset, 1'b1)
      `CHK(dma_reset_n, 1'b0)
      apb(1'b1, OFS_CONTROL, 32'h0000_0000);
      rchk(OFS_LAST_TRIGGER, 32'h0000_0000);
      rchk(OFS_REPLY_TALLY, 32'h0000_0000);
      rchk(OFS_BYTES_LOW, 32'h0000_0000);
   endtask
   task automatic block_limits();
      apb(1'b1, OFS_BLOCK_COUNT, 32'h0000_0003);
      sends = 0;
      pulses(3, 2, 32'h0000_0000);
      `CHK(sends, 0)
      pulses(3, 1, 32'h0000_0000);
      `CHK(sends, 1)
      apb(1'b1, OFS_BLOCK_COUNT, 32'h0000_0000);
      apb(1'b1, OFS_BLOCK_IDLE, 32'h0000_0004);
      pulses(3, 1, 32'h0000_0000);
      sends = 0;
      repeat (8) @(posedge pclk);
      `CHK(sends, 0)
      repeat (16) @(posedge pclk);
      `CHK(sends > 0, 1'b1)
      apb(1'b1, OFS_BLOCK_IDLE, 32'h0000_0000);
      pulses(3, 1, 32'h0000_0000);
      sends = 0;
      block_words <= 32'h0000_000F;
      memory_pointer <= 32'h0000_000F;
      repeat (3) @(posedge pclk);
      `CHK(sends, 0)
      `CHK({memory_full, memory_wrap}, 2'b01)
      block_words <= 32'h0000_0010;
      memory_pointer <= 32'h0000_0010;
      repeat (3) @(posedge pclk);
      `CHK(sends > 0, 1'b1)
      `CHK({memory_full, memory_wrap}, 2'b10)
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      data_fifo();
      length_fifo();
      counters();
      block_limits();
      complete_run();
   end
   initial begin
      #40000;
      n_errors++;
      complete_run();
   end
endmodule // readout_control_tb
`default_nettype wire
